// file: hdl/see_pkg.sv
// Package: constants and types for the serial EEPROM client port
package see_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned WR_TIME_MS    = 5;
  localparam int unsigned WR_CYCLES     = (CLK_HZ / 1000) * WR_TIME_MS;
  localparam int unsigned MEM_DEPTH     = 2048;
  localparam int unsigned ADDR_W        = 11;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PAGE_BITS     = 4;
  localparam int unsigned BUF_DEPTH     = 2;
  localparam logic [3:0]  CTL_CODE      = 4'ha;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;

  typedef enum logic [7:0] {
    SEE_IDLE  = 8'h01,
    SEE_CTL   = 8'h02,
    SEE_CACK  = 8'h04,
    SEE_WADDR = 8'h08,
    SEE_WDATA = 8'h10,
    SEE_WACK  = 8'h20,
    SEE_RDATA = 8'h40,
    SEE_RACK  = 8'h80
  } see_state_e;
endpackage : see_pkg

// file: hdl/see_buf_if.sv
// Interface: valid/ready word path into the write buffer
`timescale 1ns/1ps
interface see_buf_if;
  logic                  valid;
  logic                  ready;
  logic [7:0]            data;
  logic [10:0]           addr;
  modport src (output valid, output data, output addr, input ready);
  modport snk (input valid, input data, input addr, output ready);
endinterface : see_buf_if

// file: hdl/see_buf2.sv
// Two-entry valid/ready buffer between byte capture and array write
`timescale 1ns/1ps
module see_buf2
  import see_pkg::*;
(
  input  wire logic        i_clk,   // System clock
  input  wire logic        i_rstn,  // Async reset, active low
  see_buf_if.snk           s_in,    // Filling side
  output logic             o_valid, // Word available
  input  wire logic        i_ready, // Drain side accepts
  output logic [18:0]      o_word   // {addr, data}
);
  logic [18:0] mem_q [BUF_DEPTH];
  logic [18:0] mem_d [BUF_DEPTH];
  logic [1:0]  cnt_q, cnt_d;
  logic        push, pop;

  assign push    = s_in.valid && s_in.ready;
  assign pop     = o_valid && i_ready;
  assign s_in.ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_word  = mem_q[0];

  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (pop) begin
      mem_d[0] = mem_q[1];
    end
    if (push) begin
      if (pop) mem_d[0] = {s_in.addr, s_in.data};
      else mem_d[cnt_q[0]] = {s_in.addr, s_in.data};
    end
    if (push && pop && cnt_q == 2'h2) mem_d[1] = {s_in.addr, s_in.data};
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q    <= 2'h0;
      mem_q[0] <= 19'h0;
      mem_q[1] <= 19'h0;
    end else begin
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  buf_full_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cnt_q == 2'h2 |-> !s_in.ready)
    else $error("buffer accepts while full");
  buf_count_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    push && !pop && cnt_q != 2'h2 |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("buffer count did not rise");
endmodule : see_buf2

// file: hdl/see_client.sv
// Top: serial EEPROM client port, bit engine, array and write timer
//
// Function
// - Sample incoming bits on rising clock edge
// - Change output bit only after falling edge
// - Data line only pulled low or released
// - Write protect low: writes proceed normally
// - Write protect high: array writes blocked
// - Floating write protect reads as low
// - 2048 bytes, eleven-bit byte address
// - Page writes up to sixteen bytes, partial allowed
// - Self-timed programming finishes within 5 ms
// - Random and sequential reads supported
// - Client only; host governs every transfer
`timescale 1ns/1ps
module see_client
  import see_pkg::*;
#(
  parameter int unsigned WR_CYC = see_pkg::WR_CYCLES // Programming time
)(
  input  wire logic i_clk,    // 10 MHz system clock
  input  wire logic i_rstn,   // Async reset, active low
  input  wire logic i_scl,    // Serial clock pin
  input  wire logic i_sda,    // Serial data pin level
  output logic      o_sda,    // Serial data drive value, always low
  output logic      o_sda_oe, // Low while pulling data line low
  input  wire logic i_wp,     // Write protect, pulled down if open
  output logic      o_busy    // Internal programming in progress
);
  logic [2:0]  scl_sy_q, sda_sy_q;
  logic        scl_r, sda_r, scl_p, sda_p;
  logic        scl_rise, scl_fall, start_ev, stop_ev;
  logic [1:0]  wp_sy_q;
  logic        wp_s;
  see_state_e  st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;
  logic        rw_q, rw_d, drv_q, drv_d, nack_q, nack_d;
  logic        oe_q;
  logic        addr_hi_q, addr_hi_d, wr_mode_q, wr_mode_d;
  logic        push;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] rd_q;
  logic [22:0] tmr_q, tmr_d;
  logic        busy_q, busy_d, arm_q, arm_d;
  logic        b_valid, b_ready;
  logic [18:0] b_word;
  see_buf_if   bif ();

  // Pin inputs pass two flops; third stage only for edge detection
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      wp_sy_q  <= 2'h0;
    end else begin
      scl_sy_q <= {scl_sy_q[1:0], i_scl};
      sda_sy_q <= {sda_sy_q[1:0], i_sda};
      wp_sy_q  <= {wp_sy_q[0], i_wp};
    end
  end
  assign scl_r    = scl_sy_q[1];
  assign scl_p    = scl_sy_q[2];
  assign sda_r    = sda_sy_q[1];
  assign sda_p    = sda_sy_q[2];
  assign scl_rise = scl_r && !scl_p;
  assign scl_fall = !scl_r && scl_p;
  assign start_ev = scl_r && scl_p && !sda_r && sda_p;
  assign stop_ev  = scl_r && scl_p && sda_r && !sda_p;
  // An open pin is pulled down by the pad, so X never reaches here
  assign wp_s     = wp_sy_q[1];

  // Byte engine; host starts and paces every transfer
  always_comb begin
    st_d      = st_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    ptr_d     = ptr_q;
    rw_d      = rw_q;
    drv_d     = drv_q;
    nack_d    = nack_q;
    addr_hi_d = addr_hi_q;
    wr_mode_d = wr_mode_q;
    push      = 1'b0;
    // Clear first, so a stop in the hand-off cycle still arms
    arm_d     = arm_q && busy_q;
    if (start_ev) begin
      st_d  = SEE_CTL;
      bit_d = BIT_FIRST;
      drv_d = 1'b0;
      wr_mode_d = 1'b0;
      addr_hi_d = 1'b0;
    end else if (stop_ev) begin
      st_d  = SEE_IDLE;
      drv_d = 1'b0;
      if (wr_mode_q) arm_d = 1'b1;
      wr_mode_d = 1'b0;
    end else begin
      case (st_q)
        SEE_IDLE: begin
        end
        SEE_CTL, SEE_WADDR, SEE_WDATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_r};
            bit_d = bit_q + 3'h1;
          end else if (scl_fall && bit_q == BIT_FIRST && addr_hi_q) begin
            // After eighth bit: decide and acknowledge
            addr_hi_d = 1'b0;
            drv_d     = 1'b1;
            st_d      = SEE_CACK;
            if (st_q == SEE_CTL) begin
              rw_d = sh_q[0];
              if (sh_q[7:4] != CTL_CODE || busy_q) begin
                drv_d = 1'b0;
                st_d  = SEE_IDLE;
              end else begin
                ptr_d[10:8] = sh_q[3:1];
                st_d = sh_q[0] ? SEE_RACK : SEE_WACK;
                nack_d = sh_q[0];
              end
            end else if (st_q == SEE_WADDR) begin
              ptr_d[7:0] = sh_q;
              st_d = SEE_WACK;
              wr_mode_d = 1'b1;
            end else begin
              push = 1'b1;
              drv_d = bif.ready;
              st_d = SEE_WACK;
              // Low four bits roll over inside the page
              ptr_d[PAGE_BITS-1:0] = ptr_q[PAGE_BITS-1:0] + 4'h1;
            end
          end
          if (scl_rise && bit_q == BIT_LAST) addr_hi_d = 1'b1;
        end
        SEE_CACK: begin
          // Host answers the read byte; low asks for another
          if (scl_rise) nack_d = sda_r;
          if (scl_fall && nack_q) st_d = SEE_IDLE;
          if (scl_fall && !nack_q) begin
            sh_d  = rd_q;
            drv_d = !rd_q[7];
            bit_d = BIT_FIRST;
            st_d  = SEE_RDATA;
            ptr_d = ptr_q + 11'h1;
          end
        end
        SEE_WACK: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            bit_d = BIT_FIRST;
            st_d  = (wr_mode_q || nack_q) ? SEE_WDATA : SEE_WADDR;
            if (rw_q && !nack_q) st_d = SEE_RDATA;
          end
        end
        SEE_RACK: begin
          if (scl_fall) begin
            // Load first read byte, drive its MSB after the fall
            sh_d  = rd_q;
            drv_d = !rd_q[7];
            bit_d = BIT_FIRST;
            st_d  = SEE_RDATA;
            ptr_d = ptr_q + 11'h1;
          end
        end
        SEE_RDATA: begin
          if (scl_fall) begin
            if (bit_q == BIT_LAST) begin
              drv_d = 1'b0;
              st_d  = SEE_CACK;
              nack_d = 1'b1;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = !sh_q[6];
              bit_d = bit_q + 3'h1;
            end
          end
          if (scl_rise && bit_q == BIT_LAST) nack_d = 1'b0;
        end
        default: st_d = SEE_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q      <= SEE_IDLE;
      bit_q     <= BIT_FIRST;
      sh_q      <= 8'h0;
      ptr_q     <= 11'h0;
      rw_q      <= 1'b0;
      drv_q     <= 1'b0;
      oe_q      <= 1'b1;
      nack_q    <= 1'b0;
      addr_hi_q <= 1'b0;
      wr_mode_q <= 1'b0;
      arm_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      ptr_q     <= ptr_d;
      rw_q      <= rw_d;
      drv_q     <= drv_d;
      oe_q      <= !drv_d;
      nack_q    <= nack_d;
      addr_hi_q <= addr_hi_d;
      wr_mode_q <= wr_mode_d;
      arm_q     <= arm_d;
    end
  end

  assign bif.valid = push;
  assign bif.data  = sh_q;
  assign bif.addr  = ptr_q;

  see_buf2 u_buf (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .s_in    (bif),
    .o_valid (b_valid),
    .i_ready (b_ready),
    .o_word  (b_word)
  );

  // Array takes a word every cycle, so pages up to sixteen bytes
  // are acked in full; the buffer only rides out a stall
  assign b_ready = 1'b1;

  always_ff @(posedge i_clk) begin
    if (b_valid && b_ready && !wp_s) begin
      mem[b_word[18:8]] <= b_word[7:0];
    end
    rd_q <= mem[ptr_q];
  end

  // Programming timer, started by stop after a write
  always_comb begin
    tmr_d  = tmr_q;
    busy_d = busy_q;
    if (arm_q && !busy_q) begin
      busy_d = 1'b1;
      tmr_d  = 23'(WR_CYC - 1);
    end else if (busy_q) begin
      if (tmr_q == 23'h0 && !b_valid) busy_d = 1'b0;
      else if (tmr_q != 23'h0) tmr_d = tmr_q - 23'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tmr_q  <= 23'h0;
      busy_q <= 1'b0;
    end else begin
      tmr_q  <= tmr_d;
      busy_q <= busy_d;
    end
  end

  // Output value stays low; only the enable moves
  assign o_sda    = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_busy   = busy_q;

  sda_open_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_sda == 1'b0 && (st_q != SEE_IDLE || o_sda_oe))
    else $error("data line driven high");
  drv_fall_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_q == SEE_RDATA && $changed(drv_q) |-> $past(scl_fall))
    else $error("read bit changed away from clock fall");
  wp_block_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    b_valid && b_ready && wp_s |=> mem[$past(b_word[18:8])] ===
      $past(mem[b_word[18:8]]))
    else $error("protected array was written");
  wr_time_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(busy_q) |-> tmr_q == 23'(WR_CYC - 1))
    else $error("programming timer loaded wrong");
  page_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    push |=> ptr_q[10:4] == $past(ptr_q[10:4]))
    else $error("page write crossed page");
  busy_nack_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    busy_q && st_q == SEE_CTL && scl_fall && addr_hi_q
    |=> st_q == SEE_IDLE && o_sda_oe)
    else $error("acked while busy");
  seq_rd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_q == SEE_RACK && scl_fall |=> ptr_q == $past(ptr_q) + 11'h1)
    else $error("read address did not advance");
  wp_ok_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    b_valid && b_ready && !wp_s |=> mem[$past(b_word[18:8])] ==
      $past(b_word[7:0]))
    else $error("unprotected write lost");

  wr_cov: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(busy_q));
  rd_cov: cover property (@(posedge i_clk) disable iff (!i_rstn)
    st_q == SEE_RACK && scl_fall);
  wrap_cov: cover property (@(posedge i_clk) disable iff (!i_rstn)
    push && ptr_q[PAGE_BITS-1:0] == 4'hf);
  seq_cov: cover property (@(posedge i_clk) disable iff (!i_rstn)
    st_q == SEE_CACK && scl_fall && !nack_q);
  poll_cov: cover property (@(posedge i_clk) disable iff (!i_rstn)
    busy_q && st_q == SEE_CTL && scl_fall && addr_hi_q);
endmodule : see_client

// file: sim/see_host_model.sv
// Bus host model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module see_host_model (
  input  wire logic i_clk,     // Bench clock
  input  wire logic i_sda,     // Resolved data line level
  output logic      o_scl,     // Serial clock
  output logic      o_sda_low  // Pulls the data line low when high
);
  int stretch = 0; // Extra low-phase clocks for a slow host

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Data only changes while the clock is low
  task automatic bit_out(input logic b);
    o_scl <= 1'b0;
    tick(2 + stretch);
    o_sda_low <= ~b;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
  endtask

  // Samples twice while the clock is high to catch a moving data line
  task automatic bit_in(output logic b, output logic st);
    logic s1;
    o_scl <= 1'b0;
    o_sda_low <= 1'b0;
    tick(4 + stretch);
    o_scl <= 1'b1;
    tick(2);
    @(negedge i_clk) s1 = i_sda;
    tick(2);
    @(negedge i_clk) b = i_sda;
    st = (s1 === b);
    tick(1);
  endtask

  task automatic start;
    o_scl <= 1'b0;
    tick(4);
    o_sda_low <= 1'b0;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    o_sda_low <= 1'b1;
    tick(4);
  endtask

  task automatic stop;
    o_scl <= 1'b0;
    tick(4);
    o_sda_low <= 1'b1;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    o_sda_low <= 1'b0;
    tick(4);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic st;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(ack, st);
    ack = ~ack;
  endtask

  task automatic rd_byte(output logic [7:0] d, output logic st,
                         input logic more);
    logic s;
    st = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i], s);
      st &= s;
    end
    bit_out(~more);
  endtask
endmodule // see_host_model

// file: sim/see_client_tb_top.sv
// Self-checking bench for the serial EEPROM client port
`timescale 1ns/1ps
module see_client_tb_top;
  import see_pkg::*;
  localparam int unsigned WR_SIM = 400; // Shortened programming time
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wp = 1'b0;
  logic       scl;
  logic       sda_low;
  logic       sda_drv;
  logic       sda_oe;
  logic       busy;
  logic       sda_w;
  int         failures = 0;
  int         n_tests = 0;
  int         seed = 62899;
  logic [7:0] mem_ref [int];

  // Wired-AND with pull-up: any party pulling low wins
  assign sda_w = (sda_low || (sda_oe === 1'b0 && sda_drv === 1'b0)) ?
                 1'b0 : 1'b1;

  always #50 clk = ~clk;

  see_client #(.WR_CYC(WR_SIM)) see_client_i (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda_w),
    .o_sda(sda_drv), .o_sda_oe(sda_oe), .i_wp(wp), .o_busy(busy));

  see_host_model see_host_model_i (
    .i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Page writes roll over inside the sixteen-byte page
  function automatic logic [10:0] page_addr(input logic [10:0] a,
                                            input int i);
    return {a[10:4], 4'(a[3:0] + 4'(i))};
  endfunction

  task automatic ctl(input logic [10:0] a, input logic rd, input logic ex);
    logic ack;
    see_host_model_i.start();
    see_host_model_i.wr_byte({CTL_CODE, a[10:8], rd}, ack);
    check("ctl ack", ack, ex);
  endtask

  task automatic write(input logic [10:0] a, input int n, input logic poll);
    logic       ack;
    logic [7:0] d;
    int         t;
    ctl(a, 1'b0, 1'b1);
    see_host_model_i.wr_byte(a[7:0], ack);
    check("addr ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      see_host_model_i.wr_byte(d, ack);
      check("data ack", ack, 1'b1);
      if (wp === 1'b0) mem_ref[page_addr(a, i)] = d;
    end
    see_host_model_i.stop();
    see_host_model_i.tick(4);
    if (wp === 1'b0) check("busy", busy, 1'b1);
    if (poll) begin
      ctl(a, 1'b0, 1'b0);
      see_host_model_i.stop();
    end
    t = 0;
    while (busy !== 1'b0 && t < 2 * WR_SIM) begin
      @(posedge clk);
      t++;
    end
    check("write time", 16'(t <= WR_SIM), 1'b1);
  endtask

  task automatic read(input logic [10:0] a, input int n);
    logic       ack;
    logic       st;
    logic [7:0] d;
    logic [10:0] p;
    ctl(a, 1'b0, 1'b1);
    see_host_model_i.wr_byte(a[7:0], ack);
    check("addr ack", ack, 1'b1);
    ctl(a, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      p = a + 11'(i);
      see_host_model_i.rd_byte(d, st, i < n - 1);
      check("out stable", st, 1'b1);
      if (mem_ref.exists(p)) check("read data", d, mem_ref[p]);
    end
    see_host_model_i.stop();
  endtask

  initial begin
    logic [10:0] a;
    logic        ack;
    see_host_model_i.tick(3);
    rstn <= 1'b1;
    see_host_model_i.tick(3);
    check("idle pins", {sda_drv, sda_oe, busy}, 3'h2);
    see_host_model_i.start();
    see_host_model_i.wr_byte(~{CTL_CODE, 4'h0}, ack);
    check("foreign code", ack, 1'b0);
    see_host_model_i.stop();
    $display("test refusal done");
    for (int k = 0; k < 6; k++) begin
      a = 11'($random(seed));
      see_host_model_i.stretch = k % 3;
      write(a, 1 + k % 2, 1'b0);
      read(a, 2);
    end
    see_host_model_i.stretch = 0;
    $display("test random done");
    a = {7'($random(seed)), 4'he};
    write(a, 4, 1'b0); // Crosses the page end, must wrap
    read({a[10:4], 4'h0}, 16);
    write(11'h7f0, 16, 1'b1); // Full last page, polled while busy
    read(11'h7f0, 16);
    $display("test page done");
    wp <= 1'b1;
    write(11'h7f0, 3, 1'b0); // Acked but must not be stored
    wp <= 1'b0;
    read(11'h7f0, 3);
    $display("test protect done");
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule // see_client_tb_top
